// *** hdl/nclc_top.sv ***
// The AHB-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "nclc_map.svh"
// How it works
// R1 - A 16-bit version word holds the version in bits 3..0, upper bits reserved.
// R2 - Version reads 0001; 0000 and 1111 both mean no version present.
// R3 - The information area reads only while internal resource mapping is active.
// R4 - Software writes the divider after reset before any program or erase.
// R5 - Software keeps the bus clock above 0.8 MHz and picks the divider carefully.
// R6 - Any divider write sets the loaded flag; reset clears it.
// R7 - Program or erase with the loaded flag clear sets access error instead.
// R8 - Software clears error flags and checks completion before launching.
// R9 - While completion is zero, launches and parameter writes are ignored.
// R10 - Parameter words are selected through the index register.
// R11 - Writing one to completion clears it and launches the command.
// R12 - Completion stays clear until done, then sets and results are returned.
// R13 - Special mode and secured inputs select which commands are valid.
// R14 - Codes 01 and 02 verify all blocks or one block erased.
// R15 - Code 03 verifies a span of program words erased.
// R16 - Codes 04 and 07 read and program the once-only 64-byte field.
// R17 - Code 06 programs a phrase; code 0A erases a sector.
// R18 - Code 08 needs all program protection bits and data open set.
// R19 - Code 09 needs low, high and open program protection bits set.
// R20 - Codes 0B and 0C release security by erase or by key check.
// R21 - Codes 0D and 0E set margin levels; 0E only in special mode.
// R22 - Command code is the high byte of word 0, address follows.
// R23 - An unknown command code sets access error and is not run.
// R24 - A code invalid for mode and security sets access error at launch.
module nclc_top
   import nclc_pkg::*;
#(
   parameter logic [3:0] VERSION = 4'h1
)(
   // Clock, reset and enable.
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // AHB-Lite slave.
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic hreadyout_o,
   output logic [31:0] hrdata_o,
   output logic hresp_o,
   // Mode pins.
   input wire logic special_mode_i,
   input wire logic secure_i,
   input wire logic internal_resource_mapping_i,
   // Memory controller.
   output logic mc_start_o,
   output nclc_cmd_t mc_code_o,
   output logic [17:0] mc_addr_o,
   input wire logic mc_done_i,
   input wire logic [15:0] mc_result_i
);
   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic sp1;
      logic sp2;
      logic se1;
      logic se2;
      logic [6:0] divide_value;
      logic divider_loaded_flag;
      logic [2:0] parameter_index;
      logic command_complete_flag;
      logic access_error_flag;
      logic protection_violation_flag;
      logic [3:0] prot;
      logic [5:0][15:0] ccob;
      logic go;
      logic wr_pend;
      logic rd_pend;
      logic [7:0] addr;
      logic hready;
      logic [31:0] hrdata;
   } nclc_state_t;
   nclc_state_t s, n;

   nclc_mc_if mc ();
   nclc_verdict_t verdict;
   logic launch_req;
   logic [31:0] rd_mux;

   ////////////////////////////////////////////////////////////////////////////
   // R13 mode check
   nclc_decode u_decode (
      .code_i(s.ccob[0][15:8]),
      .special_i(s.sp2),
      .secure_i(s.se2),
      .prot_i(s.prot),
      .verdict_o(verdict)
   );

   nclc_engine u_engine (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .mc(mc.eng),
      .mc_start_o(mc_start_o),
      .mc_code_o(mc_code_o),
      .mc_addr_o(mc_addr_o),
      .mc_done_i(mc_done_i),
      .mc_result_i(mc_result_i)
   );

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      n = s;
      n.go = 1'b0;
      n.wr_pend = 1'b0;
      // The special mode and secure pins are resynchronised; only the second stage is read.
      n.sp1 = special_mode_i;
      n.sp2 = s.sp1;
      n.se1 = secure_i;
      n.se2 = s.se1;
      rd_mux = 32'h0000_0000;
      launch_req = 1'b0;
      unique case (s.addr)
         `NCLC_OFS_CLKDIV: rd_mux = {24'h00_0000, s.divider_loaded_flag, s.divide_value};
         `NCLC_OFS_PIDX: rd_mux = {29'h0000_0000, s.parameter_index};
         `NCLC_OFS_STAT: begin
            rd_mux[`NCLC_STAT_COMMAND_COMPLETE_FLAG_BIT] = s.command_complete_flag;
            rd_mux[`NCLC_STAT_ACCESS_ERROR_FLAG_BIT] = s.access_error_flag;
            rd_mux[`NCLC_STAT_PROTECTION_VIOLATION_FLAG_BIT] = s.protection_violation_flag;
         end
         // R10 indexed parameter read
         `NCLC_OFS_CCOB: if (s.parameter_index < `NCLC_CCOB_WORDS) begin
            rd_mux = {16'h0000, s.ccob[s.parameter_index]};
         end
         `NCLC_OFS_PROT: rd_mux = {28'h000_0000, s.prot};
         // R3 gated information area
         `NCLC_OFS_INFO: if (internal_resource_mapping_i) begin
            // R1 version word layout
            rd_mux[3:0] = VERSION;
            // R2 no-version patterns
            rd_mux[`NCLC_INFO_PRESENT_BIT] = (VERSION != `NCLC_VER_NONE0) && (VERSION != `NCLC_VER_NONE1);
         end
         default: rd_mux = 32'h0000_0000;
      endcase
      if (s.rd_pend) begin
         n.hrdata = rd_mux;
         n.hready = 1'b1;
         n.rd_pend = 1'b0;
      end
      if (s.wr_pend) begin
         unique case (s.addr)
            // R6 divider loaded
            `NCLC_OFS_CLKDIV: begin
               n.divide_value = hwdata_i[6:0];
               n.divider_loaded_flag = 1'b1;
            end
            // R10 index select
            `NCLC_OFS_PIDX: n.parameter_index = hwdata_i[2:0];
            // R9 array locked while busy
            `NCLC_OFS_CCOB: if (s.command_complete_flag && s.parameter_index < `NCLC_CCOB_WORDS) begin
               n.ccob[s.parameter_index] = hwdata_i[15:0];
            end
            `NCLC_OFS_PROT: n.prot = hwdata_i[3:0];
            `NCLC_OFS_STAT: begin
               if (hwdata_i[`NCLC_STAT_ACCESS_ERROR_FLAG_BIT]) begin
                  n.access_error_flag = 1'b0;
               end
               if (hwdata_i[`NCLC_STAT_PROTECTION_VIOLATION_FLAG_BIT]) begin
                  n.protection_violation_flag = 1'b0;
               end
               // R8 stale errors block launch
               launch_req = hwdata_i[`NCLC_STAT_COMMAND_COMPLETE_FLAG_BIT] && s.command_complete_flag &&
                  !n.access_error_flag && !n.protection_violation_flag;
            end
            default: ;
         endcase
      end
      if (launch_req) begin
         // R7 divider not loaded
         // R23 unknown code
         // R24 invalid for mode
         if (verdict.unknown || verdict.bad_mode || (verdict.pe && !s.divider_loaded_flag)) begin
            n.access_error_flag = 1'b1;
         end else if (verdict.prot_err) begin
            n.protection_violation_flag = 1'b1;
         end else begin
            // R11 clear and launch
            n.command_complete_flag = 1'b0;
            n.go = 1'b1;
         end
      end
      // R12 completion sets flag
      if (mc.done) begin
         n.command_complete_flag = 1'b1;
         n.ccob[`NCLC_RES_IDX] = mc.result;
      end
      if (hsel_i && htrans_i[1] && hready_i && s.hready) begin
         n.addr = haddr_i[7:0];
         n.wr_pend = hwrite_i;
         n.rd_pend = !hwrite_i;
         n.hready = hwrite_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
         s.divide_value <= `NCLC_DIV_RST;
         s.parameter_index <= `NCLC_PIDX_RST;
         s.prot <= `NCLC_PROT_RST;
         s.command_complete_flag <= 1'b1;
         s.hready <= 1'b1;
      end else if (ce_i) begin
         s <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // R22 code and address fields
   assign mc.go = s.go;
   assign mc.code = s.ccob[0][15:8];
   assign mc.addr = {s.ccob[0][1:0], s.ccob[1]};
   assign hreadyout_o = s.hready;
   assign hrdata_o = s.hrdata;
   // Only OKAY is ever answered, so an unmapped access simply reads zero.
   assign hresp_o = s.rd_pend & 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // Checks are clocked only on enabled edges, matching the frozen state.
   default clocking cb @(posedge clk_i iff ce_i); endclocking
   default disable iff (rst_i);

   ld_flag_set_a: assert property ( // R6
      s.wr_pend && s.addr == `NCLC_OFS_CLKDIV |=> s.divider_loaded_flag ##1 s.divider_loaded_flag)
      else $error("Divider loaded flag not set by write.");
   ld_flag_hold_a: assert property ( // R6
      s.divider_loaded_flag |=> s.divider_loaded_flag)
      else $error("Divider loaded flag dropped without reset.");
   pe_blocked_a: assert property ( // R7
      launch_req && verdict.pe && !s.divider_loaded_flag |=> s.access_error_flag && s.command_complete_flag && !s.go)
      else $error("Program or erase ran without divider.");
   busy_lock_a: assert property ( // R9
      s.wr_pend && s.addr == `NCLC_OFS_CCOB && !s.command_complete_flag && !mc.done |=> s.ccob == $past(s.ccob))
      else $error("Parameter array changed while busy.");
   launch_go_a: assert property ( // R11
      launch_req && !verdict.unknown && !verdict.bad_mode && !verdict.prot_err && s.divider_loaded_flag
      |=> !s.command_complete_flag && s.go ##1 !s.go)
      else $error("Launch did not clear completion and start.");
   busy_hold_a: assert property ( // R12
      !s.command_complete_flag && !mc.done |=> !s.command_complete_flag)
      else $error("Completion flag rose before done.");
   done_result_a: assert property ( // R12
      mc.done |=> s.command_complete_flag && s.ccob[`NCLC_RES_IDX] == $past(mc.result))
      else $error("Completion did not return result.");
   bad_code_a: assert property ( // R23
      launch_req && verdict.unknown |=> s.access_error_flag && !s.go)
      else $error("Unknown command not refused.");
   field_mode_a: assert property ( // R21
      launch_req && s.ccob[0][15:8] == `NCLC_CMD_FMARG && !s.sp2 |=> s.access_error_flag)
      else $error("Field margin accepted outside special mode.");
   erase_all_a: assert property ( // R18
      launch_req && s.ccob[0][15:8] == `NCLC_CMD_ERALL && s.sp2 && s.divider_loaded_flag && !(&s.prot)
      |=> s.protection_violation_flag && s.command_complete_flag)
      else $error("Erase all ran with protection set.");
   info_gate_a: assert property ( // R3
      s.rd_pend && s.addr == `NCLC_OFS_INFO && !internal_resource_mapping_i |=> hreadyout_o && hrdata_o == 32'h0)
      else $error("Information area read while unmapped.");
   ver_read_a: assert property ( // R1
      s.rd_pend && s.addr == `NCLC_OFS_INFO && internal_resource_mapping_i |=> hrdata_o[15:0] == {12'h000, VERSION})
      else $error("Version word read wrong.");

   ld_flag_idle_a: assert property ( // R6
      !s.divider_loaded_flag && !(s.wr_pend && s.addr == `NCLC_OFS_CLKDIV) |=> !s.divider_loaded_flag)
      else $error("Divider loaded flag set without a write.");

   busy_no_go_a: assert property ( // R9
      !s.command_complete_flag |=> !s.go)
      else $error("Launch started while a command was active.");

   go_busy_a: assert property ( // R11
      s.go |-> !s.command_complete_flag)
      else $error("Launch left completion set.");

   pidx_load_a: assert property ( // R10
      s.wr_pend && s.addr == `NCLC_OFS_PIDX |=> s.parameter_index == $past(hwdata_i[2:0]))
      else $error("Parameter index not loaded.");

   word_load_a: assert property ( // R10
      s.wr_pend && s.addr == `NCLC_OFS_CCOB && s.command_complete_flag && s.parameter_index == 3'h0
      |=> s.ccob[0] == $past(hwdata_i[15:0]))
      else $error("Parameter word not loaded while idle.");

   idx_void_a: assert property ( // R10
      s.rd_pend && s.addr == `NCLC_OFS_CCOB && s.parameter_index > 3'h5 |=> hrdata_o == 32'h0000_0000)
      else $error("Unused parameter word did not read zero.");

   code_pass_a: assert property ( // R22
      s.go |=> mc_code_o == $past(s.ccob[0][15:8]) && mc_addr_o[15:0] == $past(s.ccob[1]) &&
      mc_addr_o[17:16] == $past(s.ccob[0][1:0]))
      else $error("Command code or address not passed on.");

   ver_fields_a: assert property ( // R2
      s.rd_pend && s.addr == `NCLC_OFS_INFO && internal_resource_mapping_i
      |=> hrdata_o[15:4] == 12'h000 && hrdata_o[`NCLC_INFO_PRESENT_BIT] == (VERSION != 4'h0 && VERSION != 4'hF))
      else $error("Version presence bit wrong.");

   err_sticky_a: assert property ( // R7
      s.access_error_flag && !(s.wr_pend && s.addr == `NCLC_OFS_STAT && hwdata_i[`NCLC_STAT_ACCESS_ERROR_FLAG_BIT])
      |=> s.access_error_flag)
      else $error("Access error cleared without a write.");

   mode_refuse_a: assert property ( // R24
      launch_req && verdict.bad_mode |=> s.access_error_flag && !s.go)
      else $error("Command invalid for mode was launched.");

   prot_refuse_a: assert property ( // R18
      launch_req && verdict.prot_err |=> !s.go)
      else $error("Protected erase was launched.");

   blk_gate_a: assert property ( // R19
      launch_req && s.ccob[0][15:8] == `NCLC_CMD_ERBLK && !(&s.prot[2:0]) |=> !s.go)
      else $error("Block erase ran with protection set.");

   key_mode_a: assert property ( // R13
      launch_req && s.ccob[0][15:8] == `NCLC_CMD_BDKEY && s.sp2 |=> s.access_error_flag)
      else $error("Key check accepted in special mode.");

   unsec_mode_a: assert property ( // R20
      launch_req && s.ccob[0][15:8] == `NCLC_CMD_UNSEC && !s.sp2 |=> s.access_error_flag && !s.go)
      else $error("Security release by erase accepted in normal mode.");

   verify_free_a: assert property ( // R14
      launch_req && (s.ccob[0][15:8] == `NCLC_CMD_EVA || s.ccob[0][15:8] == `NCLC_CMD_EVB)
      |=> s.go && !s.command_complete_flag)
      else $error("Erase verify was refused.");

   section_ok_a: assert property ( // R15
      launch_req && s.ccob[0][15:8] == `NCLC_CMD_EVS && !s.se2 |=> s.go)
      else $error("Section verify refused while unsecured.");

   once_secure_a: assert property ( // R16
      launch_req && s.ccob[0][15:8] == `NCLC_CMD_PONCE && s.se2 |=> !s.go)
      else $error("Once-only program ran while secured.");

   sector_secure_a: assert property ( // R17
      launch_req && s.ccob[0][15:8] == `NCLC_CMD_ERSEC && s.se2 |=> !s.go)
      else $error("Sector erase ran while secured.");

   launch_c: cover property (launch_req ##1 s.go ##[1:20] mc.done);
   refuse_c: cover property (launch_req ##1 s.access_error_flag);
   prot_c: cover property (launch_req ##1 s.protection_violation_flag);
   busy_write_c: cover property (s.wr_pend && s.addr == `NCLC_OFS_CCOB && !s.command_complete_flag);
   info_off_c: cover property (s.rd_pend && s.addr == `NCLC_OFS_INFO && !internal_resource_mapping_i);
endmodule : nclc_top

// *** hdl/nclc_map.svh ***
`ifndef NCLC_MAP_SVH
`define NCLC_MAP_SVH
// Register byte offsets on the bus (haddr[7:0]).
`define NCLC_OFS_CLKDIV 8'h00
`define NCLC_OFS_PIDX 8'h04
`define NCLC_OFS_STAT 8'h08
`define NCLC_OFS_CCOB 8'h0C
`define NCLC_OFS_PROT 8'h10
`define NCLC_OFS_INFO 8'h14
// Address of the version word inside the information area.
`define NCLC_INFO_VER_ADDR 18'h040B6
// Field positions.
`define NCLC_CLKDIV_LD_BIT 7
`define NCLC_STAT_COMMAND_COMPLETE_FLAG_BIT 7
`define NCLC_STAT_ACCESS_ERROR_FLAG_BIT 5
`define NCLC_STAT_PROTECTION_VIOLATION_FLAG_BIT 4
`define NCLC_PROT_LOW_BIT 0
`define NCLC_PROT_HIGH_BIT 1
`define NCLC_PROT_OPEN_BIT 2
`define NCLC_PROT_DOPEN_BIT 3
`define NCLC_INFO_PRESENT_BIT 16
// Reset values and array layout.
`define NCLC_DIV_RST 7'h00
`define NCLC_PROT_RST 4'h0
`define NCLC_PIDX_RST 3'h0
`define NCLC_CCOB_WORDS 3'h6
`define NCLC_RES_IDX 3'h2
// Version numbers that mean no version.
`define NCLC_VER_NONE0 4'h0
`define NCLC_VER_NONE1 4'hF
// Command codes.
`define NCLC_CMD_EVA 8'h01
`define NCLC_CMD_EVB 8'h02
`define NCLC_CMD_EVS 8'h03
`define NCLC_CMD_RONCE 8'h04
`define NCLC_CMD_PGM 8'h06
`define NCLC_CMD_PONCE 8'h07
`define NCLC_CMD_ERALL 8'h08
`define NCLC_CMD_ERBLK 8'h09
`define NCLC_CMD_ERSEC 8'h0A
`define NCLC_CMD_UNSEC 8'h0B
`define NCLC_CMD_BDKEY 8'h0C
`define NCLC_CMD_UMARG 8'h0D
`define NCLC_CMD_FMARG 8'h0E
`endif

// *** hdl/nclc_pkg.sv ***
package nclc_pkg;
   typedef logic [7:0] nclc_cmd_t;
   typedef enum logic {NCLC_IDLE, NCLC_RUN} nclc_eng_st_t;
   typedef struct packed {
      logic unknown;
      logic bad_mode;
      logic pe;
      logic prot_err;
   } nclc_verdict_t;
endpackage : nclc_pkg

// *** hdl/nclc_mc_if.sv ***
`timescale 1ns/1ps
interface nclc_mc_if;
   import nclc_pkg::*;
   logic go;
   nclc_cmd_t code;
   logic [17:0] addr;
   logic done;
   logic [15:0] result;
   modport main (output go, code, addr, input done, result);
   modport eng (input go, code, addr, output done, result);
endinterface : nclc_mc_if

// *** hdl/nclc_decode.sv ***
`timescale 1ns/1ps
`include "nclc_map.svh"
module nclc_decode
   import nclc_pkg::*;
(
   // Command and context.
   input wire nclc_cmd_t code_i,
   input wire logic special_i,
   input wire logic secure_i,
   input wire logic [3:0] prot_i,
   // Verdict.
   output nclc_verdict_t verdict_o
);
   always_comb begin
      verdict_o = '0;
      unique case (code_i)
         // R14 verify always valid
         `NCLC_CMD_EVA, `NCLC_CMD_EVB: ;
         // R15 R16 R21 unsecured only
         `NCLC_CMD_EVS, `NCLC_CMD_RONCE, `NCLC_CMD_UMARG: verdict_o.bad_mode = secure_i;
         // R16 R17 program and sector erase unsecured only
         `NCLC_CMD_PGM, `NCLC_CMD_PONCE, `NCLC_CMD_ERSEC: begin
            verdict_o.pe = 1'b1;
            verdict_o.bad_mode = secure_i;
         end
         // R18 erase all gate
         `NCLC_CMD_ERALL: begin
            verdict_o.pe = 1'b1;
            verdict_o.bad_mode = !special_i;
            verdict_o.prot_err = !(&prot_i);
         end
         // R19 block erase gate
         `NCLC_CMD_ERBLK: begin
            verdict_o.pe = 1'b1;
            verdict_o.bad_mode = secure_i;
            verdict_o.prot_err = !(&prot_i[2:0]);
         end
         // R20 security release modes
         `NCLC_CMD_UNSEC: begin
            verdict_o.pe = 1'b1;
            verdict_o.bad_mode = !special_i;
         end
         `NCLC_CMD_BDKEY: verdict_o.bad_mode = special_i;
         // R21 special modes only
         `NCLC_CMD_FMARG: verdict_o.bad_mode = !special_i;
         // R23 unknown code
         default: verdict_o.unknown = 1'b1;
      endcase
   end
endmodule : nclc_decode

// *** hdl/nclc_engine.sv ***
`timescale 1ns/1ps
module nclc_engine
   import nclc_pkg::*;
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Launch side.
   nclc_mc_if.eng mc,
   // Memory controller.
   output logic mc_start_o,
   output nclc_cmd_t mc_code_o,
   output logic [17:0] mc_addr_o,
   input wire logic mc_done_i,
   input wire logic [15:0] mc_result_i
);
   typedef struct packed {
      nclc_eng_st_t st;
      logic start;
      nclc_cmd_t code;
      logic [17:0] addr;
      logic done;
      logic [15:0] result;
   } nclc_eng_t;
   nclc_eng_t s, n;

   always_comb begin
      n = s;
      n.start = 1'b0;
      n.done = 1'b0;
      unique case (s.st)
         NCLC_IDLE: if (mc.go) begin
            n.st = NCLC_RUN;
            n.start = 1'b1;
            n.code = mc.code;
            n.addr = mc.addr;
         end
         // R12 completion returns results
         NCLC_RUN: if (mc_done_i) begin
            n.st = NCLC_IDLE;
            n.done = 1'b1;
            n.result = mc_result_i;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
      end else if (ce_i) begin
         s <= n;
      end
   end

   assign mc.done = s.done;
   assign mc.result = s.result;
   assign mc_start_o = s.start;
   assign mc_code_o = s.code;
   assign mc_addr_o = s.addr;

   start_pulse_a: assert property (@(posedge clk_i iff ce_i) disable iff (rst_i) // R11
      mc.go && s.st == NCLC_IDLE |=> mc_start_o ##1 !mc_start_o)
      else $error("Start pulse not one cycle after launch.");
endmodule : nclc_engine

// *** dv/test_nvm_command_launch_control.sv ***
`timescale 1ns/1ps
`include "nclc_map.svh"
module test_nvm_command_launch_control;
   import nclc_pkg::*;
   logic clk_i, rst_i, ce_i, hsel_i, hwrite_i, hready_i, hreadyout_o, hresp_o;
   logic [31:0] haddr_i, hwdata_i, hrdata_o;
   logic [1:0] htrans_i;
   logic [2:0] hsize_i;
   logic special_mode_i, secure_i, internal_resource_mapping_i, mc_start_o, mc_done_i;
   nclc_cmd_t mc_code_o;
   logic [17:0] mc_addr_o;
   logic [15:0] mc_result_i;
   int errors = 0;
   int tests_run = 0;
   int starts = 0;

   ////////////////////////////////////////////////////////////////////////////////
   nclc_top nclc_top_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
      .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
      .hreadyout_o(hreadyout_o), .hrdata_o(hrdata_o), .hresp_o(hresp_o), .special_mode_i(special_mode_i),
      .secure_i(secure_i), .internal_resource_mapping_i(internal_resource_mapping_i), .mc_start_o(mc_start_o),
      .mc_code_o(mc_code_o), .mc_addr_o(mc_addr_o), .mc_done_i(mc_done_i), .mc_result_i(mc_result_i));

   // The single slave drives the bus ready.
   assign hready_i = hreadyout_o;

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // Counting every clock cycle that start is high catches a start that stands too long.
   always @(posedge clk_i) begin
      if (mc_start_o === 1'b1) starts <= starts + 1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : report_and_stop

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // A wait ends at the first clock edge that sees ready high; the watchdog ends a hung one, so a hung slave still reaches the verdict.
   task automatic wait_rdy();
      do begin
         @(posedge clk_i);
      end while (hreadyout_o !== 1'b1);
   endtask : wait_rdy

   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk_i);
      hsel_i <= 1'b1;
      htrans_i <= 2'h2;
      haddr_i <= {24'h0, a};
      hwrite_i <= w;
      wait_rdy();
      htrans_i <= 2'h0;
      hwdata_i <= d;
      wait_rdy();
      r = hrdata_o;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask : wr

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      xfer(1'b0, a, 32'h0, r);
      check(r, exp);
   endtask : rdchk

   task automatic settle(input logic spc, input logic sec, input logic [3:0] prot);
      @(posedge clk_i);
      special_mode_i <= spc;
      secure_i <= sec;
      wr(`NCLC_OFS_PROT, {28'h0, prot});
      repeat (4) @(posedge clk_i);
   endtask : settle

   // Launches one code; a zero expected status means it must run.
   task automatic launch(input nclc_cmd_t c, input logic [31:0] exp_stat);
      int s;
      wr(`NCLC_OFS_PIDX, 32'h0);
      wr(`NCLC_OFS_CCOB, {16'h0, c, 8'h03});
      s = starts;
      wr(`NCLC_OFS_STAT, 32'h80);
      repeat (3) @(posedge clk_i);
      rdchk(`NCLC_OFS_STAT, exp_stat);
      if (exp_stat === 32'h0) begin
         check(32'(starts - s), 32'h1);
         check({24'h0, mc_code_o}, {24'h0, c});
         check({14'h0, mc_addr_o}, 32'h34567);
         wr(`NCLC_OFS_CCOB, 32'hFFFF);
         wr(`NCLC_OFS_STAT, 32'h80);
         rdchk(`NCLC_OFS_STAT, 32'h0);
         @(posedge clk_i);
         mc_done_i <= 1'b1;
         mc_result_i <= {c, 8'h5A};
         @(posedge clk_i);
         mc_done_i <= 1'b0;
         repeat (3) @(posedge clk_i);
         rdchk(`NCLC_OFS_STAT, 32'h80);
         check(32'(starts - s), 32'h1);
         rdchk(`NCLC_OFS_CCOB, {16'h0, c, 8'h03});
         wr(`NCLC_OFS_PIDX, 32'h2);
         rdchk(`NCLC_OFS_CCOB, {16'h0, c, 8'h5A});
      end else begin
         wr(`NCLC_OFS_STAT, 32'h80);
         check(32'(starts - s), 32'h0);
         wr(`NCLC_OFS_STAT, 32'h30);
         rdchk(`NCLC_OFS_STAT, 32'h80);
      end
   endtask : launch

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      check({31'h0, hresp_o}, 32'h0);
      rdchk(`NCLC_OFS_CLKDIV, 32'h0);
      rdchk(`NCLC_OFS_STAT, 32'h80);
      rdchk(`NCLC_OFS_PIDX, 32'h0);
      rdchk(`NCLC_OFS_INFO, 32'h00010001);
      internal_resource_mapping_i <= 1'b0;
      rdchk(`NCLC_OFS_INFO, 32'h0);
      internal_resource_mapping_i <= 1'b1;
      rdchk(8'h18, 32'h0);
      $display("test reset done");
   endtask : t_reset

   task automatic t_nodiv();
      wr(`NCLC_OFS_PIDX, 32'h1);
      wr(`NCLC_OFS_CCOB, 32'h4567);
      wr(`NCLC_OFS_PIDX, 32'h6);
      wr(`NCLC_OFS_CCOB, 32'h1234);
      rdchk(`NCLC_OFS_CCOB, 32'h0);
      launch(`NCLC_CMD_PGM, 32'hA0);
      launch(`NCLC_CMD_EVA, 32'h0);
      $display("test divider not loaded done");
   endtask : t_nodiv

   task automatic t_div();
      wr(`NCLC_OFS_CLKDIV, 32'h15);
      rdchk(`NCLC_OFS_CLKDIV, 32'h95);
      wr(`NCLC_OFS_CLKDIV, 32'h0);
      rdchk(`NCLC_OFS_CLKDIV, 32'h80);
      // A frozen block must ignore a whole bus write.
      ce_i <= 1'b0;
      wr(`NCLC_OFS_CLKDIV, 32'h2A);
      ce_i <= 1'b1;
      rdchk(`NCLC_OFS_CLKDIV, 32'h80);
      // A second reset must forget the divider and the array again.
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rdchk(`NCLC_OFS_CLKDIV, 32'h0);
      rdchk(`NCLC_OFS_STAT, 32'h80);
      wr(`NCLC_OFS_PIDX, 32'h1);
      rdchk(`NCLC_OFS_CCOB, 32'h0);
      wr(`NCLC_OFS_CCOB, 32'h4567);
      rdchk(`NCLC_OFS_CCOB, 32'h4567);
      wr(`NCLC_OFS_CLKDIV, 32'h15);
      rdchk(`NCLC_OFS_CLKDIV, 32'h95);
      $display("test divider done");
   endtask : t_div

   // Every code from 00 to 0F in unsecured normal mode.
   task automatic t_normal();
      logic [15:0] ok;
      ok = 16'h36DE;
      settle(1'b0, 1'b0, 4'hF);
      for (int c = 0; c < 16; c++) begin
         launch(8'(c), ok[c] ? 32'h0 : 32'hA0);
      end
      $display("test normal codes done");
   endtask : t_normal

   task automatic t_modes();
      settle(1'b0, 1'b1, 4'hF);
      launch(`NCLC_CMD_EVS, 32'hA0);
      launch(`NCLC_CMD_EVB, 32'h0);
      settle(1'b1, 1'b0, 4'h0);
      launch(`NCLC_CMD_FMARG, 32'h0);
      launch(`NCLC_CMD_BDKEY, 32'hA0);
      launch(`NCLC_CMD_ERALL, 32'h90);
      settle(1'b1, 1'b0, 4'h3);
      launch(`NCLC_CMD_ERBLK, 32'h90);
      settle(1'b1, 1'b0, 4'h7);
      launch(`NCLC_CMD_ERALL, 32'h90);
      launch(`NCLC_CMD_ERBLK, 32'h0);
      settle(1'b1, 1'b1, 4'hF);
      launch(`NCLC_CMD_ERALL, 32'h0);
      launch(`NCLC_CMD_UNSEC, 32'h0);
      $display("test modes done");
   endtask : t_modes

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_i = 1'b1;
      ce_i = 1'b1;
      hsel_i = 1'b0;
      haddr_i = 32'h0;
      htrans_i = 2'h0;
      hwrite_i = 1'b0;
      hsize_i = 3'h2;
      hwdata_i = 32'h0;
      special_mode_i = 1'b0;
      secure_i = 1'b0;
      internal_resource_mapping_i = 1'b1;
      mc_done_i = 1'b0;
      mc_result_i = 16'h0;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_nodiv();
      t_div();
      t_normal();
      t_modes();
      report_and_stop();
   end

   initial begin
      #400000;
      errors++;
      report_and_stop();
   end
endmodule : test_nvm_command_launch_control
